// *** verilog/fap_map.vh ***
`ifndef FAP_MAP_VH
`define FAP_MAP_VH
// register block base and byte offsets
`define FAP_REG_BASE 16'h00F4
`define FAP_OFF_LOCK 2'h0
`define FAP_OFF_CONFIG 2'h1
`define FAP_OFF_TEST 2'h2
`define FAP_OFF_CONTROL 2'h3
// lock register field
`define FAP_LOCK_BIT 0
// config register field
`define FAP_CFG_GUARD_BIT 0
// test register fields
`define FAP_TST_STRESS_BIT 7
`define FAP_TST_GATE_DRAIN_SELECT_BIT 6
`define FAP_TST_HVSEEN_BIT 5
`define FAP_TST_LOWV_BIT 4
`define FAP_TST_OVR_BIT 3
`define FAP_TST_THRESHOLD_CHECK_ENABLE_BIT 2
`define FAP_TST_SPARE_BIT 1
// control register fields
`define FAP_CTL_SUPPLY_BIT 2
`define FAP_CTL_WIPE_BIT 1
`define FAP_CTL_ARM_BIT 0
// reset values
`define FAP_LOCK_RST 8'h00
`define FAP_CFG_RST 8'h01
`define FAP_TST_RST 8'h00
// array windows, top bit of the 16-bit address
`define FAP_WIN_HI 1'b1
`define FAP_WIN_LO 1'b0
// boot region size in kilobytes, top of the window
`define FAP_BOOT_KB_NEW 2'd2
`define FAP_BOOT_KB_OLD 2'd1
`endif

// *** verilog/fap_flash_ctrl.v ***
`include "fap_map.vh"

// How it works
// - byte/aligned reads one cycle, misaligned two
// - program one byte/word; erase whole array only
// - 2-Kbyte boot region at top protected
// - early variant: 1-Kbyte boot region instead
// - single-chip reset: array at upper half
// - expanded reset: lower half, array disabled
// - 4-byte register block at reset base
// - normal mode: lock written once per reset
// - lock set blocks config register writes
// - guard bit frozen by lock or supply
// - guard bit blocks boot program and erase
// - normal mode: test bits ignore writes, read 0
// - low supply refuses arm unless overridden
// - spare row enabled overrides row decode
// - stress enable and gate/drain select outputs
// - read-only high-voltage-seen status bit
// - threshold check: pin drives gate, timeout off
// - low-voltage reference enable output
// - supply on freezes arm, wipe, guard
// - armed: capture next array write
module fap_flash_ctrl #(
   parameter EARLY_SILICON = 0, // 1 selects the 1-Kbyte boot region
   parameter ADDR_W = 14 // word address width of the 16-bit array
) (
   input wire mclk,
   input wire reset_n,
   input wire expanded_mode, // high: expanded mode at reset
   input wire special_mode_flag, // high: special (test) mode
   input wire prog_supply_pin, // high: supply at programming level
   input wire stress_hv_raw, // high-voltage detector during stress
   // register port
   input wire [1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // cpu array port
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_wr,
   input wire cpu_word, // high: word access, low: byte
   input wire [15:0] cpu_wdata,
   output reg [15:0] cpu_rdata,
   output reg cpu_rvalid, // pulse with read data
   output reg cpu_busy, // high during second misaligned cycle
   // array macro side
   output reg [ADDR_W-1:0] arr_addr,
   output reg arr_spare_row,
   input wire [15:0] arr_rdata,
   output reg [ADDR_W-1:0] latch_addr,
   output reg [15:0] latch_data,
   output reg latch_word,
   output reg latch_hi_byte,
   output reg prog_pulse_on, // programming voltage to selected location
   output reg erase_pulse_on, // erase voltage to whole array
   output reg boot_erase_on, // erase includes boot region
   output reg stress_test_on,
   output reg gate_drain_select,
   output reg low_volt_ref_enable,
   output reg gate_from_pin,
   output reg sense_timeout_off,
   output reg array_enabled,
   output reg array_window
);
   reg flash_lock_reg; // write-once lock
   reg lock_written; // first normal-mode write taken
   reg boot_block_guard; // configuration guard bit
   reg [7:0] flash_test_reg; // test bits (hv-seen bit unused)
   reg capture_arm;
   reg wipe_select;
   reg high_voltage_apply;
   reg latched; // latches hold data since arm set
   reg mis_pend; // second half of a misaligned read pending
   reg [7:0] mis_lo; // first byte of a misaligned read
   reg [ADDR_W-1:0] mis_addr;
   reg stress_hv_seen;
   reg wr_blocked_l; // guard verdict for the latched address
   // the programming latches and the guard verdict are taken together,
   // so a later write to another address cannot open the boot region
   // while the supply is on; the verdict is held until the next capture

   // address decoding used by several processes is kept in functions so
   // the window and boot checks cannot drift apart between them.
   // true when address falls inside the currently mapped window
   function in_window;
      input [15:0] a;
      input win;
      begin
         in_window = (a[15] == win);
      end
   endfunction

   // true when address is inside the protected boot region
   function in_boot;
      input [15:0] a;
      begin
         if (EARLY_SILICON != 0) begin
            in_boot = (a[14:10] == 5'h1F);
         end else begin
            in_boot = (a[14:11] == 4'hF);
         end
      end
   endfunction

   wire normal_mode = ~special_mode_flag;
   // register decode uses the byte offset only; the block base is placed
   // by the bus decoder outside, at the reset base of the register block
   wire arr_hit = array_enabled & in_window(cpu_addr, array_window);
   wire wr_lock = reg_wr & (reg_addr == `FAP_OFF_LOCK);
   wire wr_cfg = reg_wr & (reg_addr == `FAP_OFF_CONFIG);
   wire wr_tst = reg_wr & (reg_addr == `FAP_OFF_TEST);
   wire wr_ctl = reg_wr & (reg_addr == `FAP_OFF_CONTROL);
   wire override = flash_test_reg[`FAP_TST_OVR_BIT];
   wire spare_on = flash_test_reg[`FAP_TST_SPARE_BIT] & special_mode_flag;
   wire arm_ok = prog_supply_pin | override;
   wire new_arm = reg_wdata[`FAP_CTL_ARM_BIT];
   wire new_supply = reg_wdata[`FAP_CTL_SUPPLY_BIT];
   // writes protected by the guard bit still reach the latches; only the program pulse is held off
   wire wr_blocked = boot_block_guard & in_boot(cpu_addr);
   // a misaligned word starts at an odd byte and needs the next word too
   wire mis = cpu_word & cpu_addr[0];
   wire [ADDR_W-1:0] cpu_waddr = cpu_addr[ADDR_W:1];

   // the map is taken from the mode strap on the first edge after reset;
   // in expanded modes the array sits in the lower window but stays
   // disabled, so the strap is sampled again until the lock register is
   // written or set; the map itself is left to the resource-mapping logic outside.
   // the lock bit is write-once per reset in normal modes: the first write
   // counts even when it writes 0, which is the safe reading for software
   // that only wants to leave the configuration open.
   // special mode lets the lock be set and cleared freely for test.
   // map, lock and configuration registers
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         array_window <= `FAP_WIN_HI;
         array_enabled <= 1'b0;
         flash_lock_reg <= 1'b0;
         lock_written <= 1'b0;
         boot_block_guard <= 1'b1;
      end else begin
         // strap sampled after release: map follows the mode
         if (!lock_written && !array_enabled && !flash_lock_reg) begin
            array_window <= expanded_mode ? `FAP_WIN_LO : `FAP_WIN_HI;
            array_enabled <= ~expanded_mode;
         end
         if (wr_lock && (special_mode_flag || !lock_written)) begin
            flash_lock_reg <= reg_wdata[`FAP_LOCK_BIT];
            lock_written <= normal_mode | lock_written;
         end
         // guard moves only when unlocked and no supply applied
         if (wr_cfg && !flash_lock_reg && !high_voltage_apply) begin
            boot_block_guard <= reg_wdata[`FAP_CFG_GUARD_BIT];
         end
      end
   end

   // in normal mode the test bits are forced back to 0 every cycle, so a
   // stray write or a mode change cannot leave a stress or spare-row
   // setting behind; the cost is that test settings do not survive a
   // return to normal mode.
   // test register: writable only in special mode
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flash_test_reg <= `FAP_TST_RST;
      end else if (normal_mode) begin
         flash_test_reg <= `FAP_TST_RST;
      end else if (wr_tst) begin
         flash_test_reg <= reg_wdata;
      end
   end

   // the status bit only reports while stress is enabled, so a supply
   // left high outside a stress test does not show as a stress result
   // high-voltage status during stress, read only
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stress_hv_seen <= 1'b0;
      end else begin
         stress_hv_seen <= stress_hv_raw & flash_test_reg[`FAP_TST_STRESS_BIT];
      end
   end

   // the supply bit can only be raised with the arm bit held and the
   // latches filled; while the supply is on, arm and wipe are frozen so
   // the address and data under high voltage cannot be swapped mid-pulse.
   // clearing the supply bit is always taken.
   // control register: arm, wipe and supply interlocks
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         capture_arm <= 1'b0;
         wipe_select <= 1'b0;
         high_voltage_apply <= 1'b0;
      end else if (wr_ctl) begin
         if (!high_voltage_apply) begin
            // arm can always clear; setting needs supply or override
            if (!new_arm || arm_ok) begin
               capture_arm <= new_arm;
            end
            wipe_select <= reg_wdata[`FAP_CTL_WIPE_BIT];
         end
         // supply needs arm held and latches written first
         high_voltage_apply <= new_supply & capture_arm & latched &
                              (new_arm | high_voltage_apply);
      end
   end

   // only the first array write after arming is captured; later writes
   // are dropped until arm is cleared, which also empties the latches.
   // misaligned word writes are refused as they would span two words.
   // programming latches fill on first array write after arming
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latched <= 1'b0;
         latch_addr <= {ADDR_W{1'b0}};
         latch_data <= 16'h0000;
         latch_word <= 1'b0;
         latch_hi_byte <= 1'b0;
      end else if (!capture_arm) begin
         latched <= 1'b0;
      end else if (cpu_wr && arr_hit && !latched && !high_voltage_apply &&
                   !(cpu_word && cpu_addr[0])) begin
         // misaligned words refused: one byte or aligned word only
         latched <= 1'b1;
         latch_addr <= cpu_waddr;
         latch_data <= cpu_wdata;
         latch_word <= cpu_word;
         latch_hi_byte <= ~cpu_addr[0];
      end
   end

   // the pulses follow the supply bit one cycle late; the timing of each
   // pulse is left to the programming software, which turns the supply
   // bit on and off.
   // a blocked program still lets the supply bit be set, so software sees
   // no error here; the boot contents simply stay as they were.
   // pulses to the array macro; erase covers the boot region only while the guard bit is clear
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prog_pulse_on <= 1'b0;
         erase_pulse_on <= 1'b0;
         boot_erase_on <= 1'b0;
      end else begin
         prog_pulse_on <= high_voltage_apply & ~wipe_select & ~wr_blocked_l;
         erase_pulse_on <= high_voltage_apply & wipe_select;
         boot_erase_on <= high_voltage_apply & wipe_select & ~boot_block_guard;
      end
   end

   // guard check on the latched address, held while supply is on
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_blocked_l <= 1'b0;
      end else if (cpu_wr && arr_hit && capture_arm && !latched) begin
         wr_blocked_l <= wr_blocked;
      end
   end

   // the array answers combinationally: in the first cycle it shows the
   // word of the cpu address, and in the second cycle of a misaligned
   // read it shows the word on arr_addr, which is then the next word.
   // byte order is big-endian: the even byte is the upper half of a word.
   // reads while the supply is on are ignored and give no valid pulse.
   // array reads; a misaligned word takes a second cycle
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         arr_addr <= {ADDR_W{1'b0}};
         arr_spare_row <= 1'b0;
         cpu_rdata <= 16'h0000;
         cpu_rvalid <= 1'b0;
         cpu_busy <= 1'b0;
         mis_pend <= 1'b0;
         mis_lo <= 8'h00;
         mis_addr <= {ADDR_W{1'b0}};
      end else begin
         arr_spare_row <= spare_on;
         cpu_rvalid <= 1'b0;
         if (mis_pend) begin
            // second cycle: next word's upper byte completes the pair
            cpu_rdata <= {mis_lo, arr_rdata[15:8]};
            cpu_rvalid <= 1'b1;
            cpu_busy <= 1'b0;
            mis_pend <= 1'b0;
         end else if (cpu_rd && arr_hit && !high_voltage_apply) begin
            arr_addr <= capture_arm && !wipe_select ? latch_addr : cpu_waddr;
            if (mis) begin
               mis_pend <= 1'b1;
               cpu_busy <= 1'b1;
               mis_lo <= arr_rdata[7:0];
               mis_addr <= cpu_waddr + {{(ADDR_W-1){1'b0}}, 1'b1};
               arr_addr <= cpu_waddr + {{(ADDR_W-1){1'b0}}, 1'b1};
            end else begin
               cpu_rdata <= cpu_word ? arr_rdata :
                            {8'h00, cpu_addr[0] ? arr_rdata[7:0] : arr_rdata[15:8]};
               cpu_rvalid <= 1'b1;
            end
         end
      end
   end

   // all test outputs are registered from the test bits, so they move
   // one cycle after the register write and never glitch on the pins.
   // test outputs straight from the test bits
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         stress_test_on <= 1'b0;
         gate_drain_select <= 1'b0;
         low_volt_ref_enable <= 1'b0;
         gate_from_pin <= 1'b0;
         sense_timeout_off <= 1'b0;
      end else begin
         stress_test_on <= flash_test_reg[`FAP_TST_STRESS_BIT];
         gate_drain_select <= flash_test_reg[`FAP_TST_GATE_DRAIN_SELECT_BIT];
         low_volt_ref_enable <= flash_test_reg[`FAP_TST_LOWV_BIT];
         gate_from_pin <= flash_test_reg[`FAP_TST_THRESHOLD_CHECK_ENABLE_BIT];
         sense_timeout_off <= flash_test_reg[`FAP_TST_THRESHOLD_CHECK_ENABLE_BIT];
      end
   end

   // read data stand only in the cycle after the strobe and are 0
   // otherwise, so an idle bus never shows stale register contents.
   // the control register reads back supply, wipe and arm in its low
   // three bits; the upper bits read 0.
   // register read data, valid the cycle after the strobe
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `FAP_OFF_LOCK: reg_rdata <= {7'h00, flash_lock_reg};
            `FAP_OFF_CONFIG: reg_rdata <= {7'h00, boot_block_guard};
            `FAP_OFF_TEST: begin
               // hv-seen bit comes from status, not the stored value
               reg_rdata <= normal_mode ? 8'h00 :
                  {flash_test_reg[7:6], stress_hv_seen, flash_test_reg[4:0]};
            end
            `FAP_OFF_CONTROL: begin
               reg_rdata <= {5'h00, high_voltage_apply, wipe_select, capture_arm};
            end
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // fap_flash_ctrl

// *** test/fap_flash_ctrl_assertions.sv ***
module fap_flash_ctrl_chk (
   input wire mclk,
   input wire reset_n,
   input wire special_mode_flag,
   input wire reg_rd,
   input wire reg_wr,
   input wire [7:0] reg_rdata,
   input wire [15:0] cpu_addr,
   input wire cpu_rd,
   input wire cpu_word,
   input wire cpu_rvalid,
   input wire cpu_busy,
   input wire arr_spare_row,
   input wire prog_pulse_on,
   input wire erase_pulse_on,
   input wire stress_test_on,
   input wire gate_drain_select,
   input wire low_volt_ref_enable,
   input wire gate_from_pin,
   input wire sense_timeout_off,
   input wire array_enabled,
   input wire array_window
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // read data stands only in the cycle after a read strobe
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("register read data outside read slot");
   AST_ALIGNED_ONE: assert property (cpu_rd && array_enabled && cpu_addr[15] == array_window
      && !cpu_busy && !(cpu_word && cpu_addr[0]) |=> cpu_rvalid)
      else $error("aligned read not answered in one cycle");
   AST_MISALIGNED_TWO: assert property (cpu_rd && cpu_word && cpu_addr[0] && array_enabled
      && cpu_addr[15] == array_window && !cpu_busy
      |=> cpu_busy && !cpu_rvalid ##1 cpu_rvalid && !cpu_busy)
      else $error("misaligned read not two cycles");
   AST_PROG_ERASE_EXCL: assert property (!(prog_pulse_on && erase_pulse_on))
      else $error("program and erase at once");
   // normal mode: test outputs hold once the cleared test bits have reached them
   AST_TEST_FROZEN: assert property (!special_mode_flag [*3] |-> $stable({stress_test_on,
      gate_drain_select, low_volt_ref_enable, gate_from_pin}))
      else $error("test output moved in normal mode");
   AST_VT_PAIR: assert property (gate_from_pin == sense_timeout_off)
      else $error("threshold check outputs disagree");
   AST_SPARE_SPECIAL: assert property (!special_mode_flag [*2] |-> !arr_spare_row)
      else $error("spare row outside special mode");
   AST_PULSE_AFTER_WRITE: assert property ($rose(prog_pulse_on)
      |-> $past(reg_wr) || $past(reg_wr, 2))
      else $error("program pulse without control write");
   AST_LOW_DISABLED: assert property (!array_window |-> !array_enabled)
      else $error("array enabled in lower window");
   COV_MIS: cover property (cpu_rd && cpu_word && cpu_addr[0]);
   COV_PROG: cover property ($rose(prog_pulse_on));
   COV_SPARE: cover property (arr_spare_row);
endmodule // fap_flash_ctrl_chk

bind fap_flash_ctrl fap_flash_ctrl_chk u_chk (.mclk, .reset_n, .special_mode_flag, .reg_rd,
   .reg_wr, .reg_rdata, .cpu_addr, .cpu_rd, .cpu_word, .cpu_rvalid, .cpu_busy,
   .arr_spare_row, .prog_pulse_on, .erase_pulse_on, .stress_test_on, .gate_drain_select,
   .low_volt_ref_enable, .gate_from_pin, .sense_timeout_off, .array_enabled, .array_window);

// *** test/fap_array_model.sv ***
// combinational array: each word holds a tag of its own address
module fap_array_model #(
   parameter ADDR_W = 14
) (
   input wire [ADDR_W-1:0] arr_addr,
   input wire arr_spare_row,
   output logic [15:0] arr_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // spare row returns a fixed pattern so a mis-route shows up
   assign arr_rdata = arr_spare_row ? 16'hA5A5 : {2'b10, arr_addr};
endmodule // fap_array_model

// *** test/test_flash_array_protect_config.sv ***
module test_flash_array_protect_config;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 0, reset_n = 0, expanded_mode = 0, special_mode_flag = 0;
   logic prog_supply_pin = 1, stress_hv_raw = 0, reg_wr = 0, reg_rd = 0;
   logic cpu_rd = 0, cpu_wr = 0, cpu_word = 0;
   logic [1:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, reg_rdata;
   logic [15:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, arr_rdata, latch_data;
   logic [13:0] arr_addr, latch_addr;
   logic cpu_rvalid, cpu_busy, arr_spare_row, prog_pulse_on, stress_test_on;
   logic gate_drain_select, low_volt_ref_enable, gate_from_pin, array_enabled, array_window;
   int n_fail = 0, comparisons = 0;
   fap_flash_ctrl DUT (.mclk, .reset_n, .expanded_mode, .special_mode_flag, .prog_supply_pin,
      .stress_hv_raw, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr,
      .cpu_rd, .cpu_wr, .cpu_word, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .cpu_busy,
      .arr_addr, .arr_spare_row, .arr_rdata, .latch_addr, .latch_data, .latch_word(),
      .latch_hi_byte(), .prog_pulse_on, .erase_pulse_on(), .boot_erase_on(),
      .stress_test_on, .gate_drain_select, .low_volt_ref_enable, .gate_from_pin,
      .sense_timeout_off(), .array_enabled, .array_window);
   // array follows the cpu word address, and the next word in a misaligned second cycle
   fap_array_model u_arr (.arr_addr(cpu_busy ? arr_addr : cpu_addr[14:1]), .arr_spare_row,
      .arr_rdata);
   initial forever #50 mclk = ~mclk;
   task end_sim;
      if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // reset held ten cycles, requests from the second edge after release
   task rst(input logic exp_mode);
      reset_n <= 0;
      expanded_mode <= exp_mode;
      repeat (10) @(posedge mclk);
      reset_n <= 1;
      repeat (2) @(posedge mclk);
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   // masked register read, data sampled in the slot after the strobe
   task rd(input logic [1:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge mclk);
      reg_addr <= a; reg_rd <= 1;
      @(posedge mclk);
      reg_rd <= 0;
      @(negedge mclk);
      chk(reg_rdata & m, exp);
   endtask
   task ard(input logic [15:0] a, input logic w, input logic [15:0] exp);
      @(posedge mclk);
      cpu_addr <= a; cpu_word <= w; cpu_rd <= 1;
      @(posedge mclk);
      cpu_rd <= 0;
      if (w && a[0]) begin
         @(negedge mclk);
         chk(cpu_busy, 1);
         @(posedge mclk);
      end
      @(negedge mclk);
      chk(cpu_rvalid, 1);
      chk(w ? cpu_rdata : cpu_rdata[7:0], exp);
   endtask
   // arm, latch one word, apply supply, look for the pulse
   task prog(input logic [15:0] a, input logic e);
      wr(3, 8'h01);
      @(posedge mclk);
      cpu_addr <= a; cpu_word <= 1; cpu_wdata <= 16'h1234; cpu_wr <= 1;
      @(posedge mclk);
      cpu_wr <= 0;
      @(negedge mclk);
      chk(latch_addr, (a - 16'h8000) >> 1);
      chk(latch_data, 16'h1234);
      wr(3, 8'h05);
      @(posedge mclk);
      @(negedge mclk);
      chk(prog_pulse_on, e);
      if (e) begin
         wr(3, 8'h04);
         rd(3, 8'h05, 8'h07);
      end
      wr(3, 8'h01);
      wr(3, 8'h00);
   endtask
   initial begin
      #300000;
      n_fail++;
      end_sim;
   end
   initial begin
      rst(0);
      chk({array_enabled, array_window}, 2'b11);
      rd(0, 8'h00, 8'hFF);
      rd(1, 8'h01, 8'hFF);
      wr(2, 8'hFF);
      rd(2, 8'h00, 8'hFF);
      ard(16'h8010, 1, 16'h8008);
      ard(16'h8011, 0, 16'h0008);
      ard(16'h8011, 1, 16'h0880);
      prog_supply_pin <= 0;
      wr(3, 8'h01);
      rd(3, 8'h00, 8'h07);
      prog_supply_pin <= 1;
      wr(0, 8'h01);
      wr(1, 8'h00);
      rd(1, 8'h01, 8'hFF);
      prog(16'h8010, 1);
      prog(16'hF800, 0);
      prog(16'hF7FE, 1);
      rst(0);
      wr(0, 8'h00);
      wr(0, 8'h01);
      rd(0, 8'h00, 8'hFF);
      wr(1, 8'h00);
      rd(1, 8'h00, 8'hFF);
      prog(16'hF800, 1);
      special_mode_flag <= 1;
      stress_hv_raw <= 1;
      wr(2, 8'hDE);
      rd(2, 8'hFE, 8'hFE);
      chk({stress_test_on, gate_drain_select, low_volt_ref_enable, gate_from_pin}, 4'hF);
      prog_supply_pin <= 0;
      wr(3, 8'h01);
      rd(3, 8'h01, 8'h07);
      wr(3, 8'h00);
      ard(16'h8010, 1, 16'hA5A5);
      wr(2, 8'h00);
      rd(2, 8'h00, 8'hDE);
      special_mode_flag <= 0;
      rst(1);
      chk({array_enabled, array_window}, 2'b00);
      end_sim;
   end
endmodule // test_flash_array_protect_config
